// ==== core/mma_pkg.sv ====
// constants for the memory map and address generation block
// assumes a 12-bit rom address and an 8-bit nibble ram address
// Behaviour
// - after reset fetching starts at program address 000h.
// - accepted interrupts load fixed vectors 002h through 00Ch by source.
// - short call targets only sixteen entries 00Eh to 086h, eight apart.
// - long call reaches only program addresses 000h to 7FFh.
// - a 12-bit table pointer, loaded only in bits 8..0, addresses rom bytes for table reads.
// - table pointer loads from accumulator in low, mid and high parts.
// - low table read returns rom bits 3..0, pointer unchanged.
// - high table read returns rom bits 7..4, then pointer increments.
// - data ram has 244 nibbles at 00h to F3h.
// - display ram 20h-3Fh refuses pointer-pair load and swap.
// - zero page 00h-0Fh is the only target of zero-page forms.
// - zero-page ops store, add, compare or clear bit at direct operand.
// - up to 13 stack levels, start level set by software.
// - calls and interrupts push return address; returns restore it.
// - indirect mode addresses ram by the pointer pair.
// - direct mode addresses ram by the instruction operand.
// - program counter is 12 bits holding next fetch address.
// - reset acts while low.
// - enabled wake-up pins release idle: port zero on the configured edge, port eight on the falling edge.
// - port eight bit 1 feeds timer b, bit 3 timer a; both wake.
// - with sound enabled, port four bit 0 drives inverted melody.
// - stack pointer decrements on entry, increments on return, not reset.
// - interrupt entry pushes pc then loads the vector.
package mma_pkg;
  localparam int PC_W = 12;
  localparam int RA_W = 8;
  localparam logic [11:0] RESET_VEC = 12'h000;
  localparam logic [11:0] VEC_EXT0 = 12'h002;
  localparam logic [11:0] VEC_FAST = 12'h004;
  localparam logic [11:0] VEC_TMRA = 12'h006;
  localparam logic [11:0] VEC_TMRB = 12'h008;
  localparam logic [11:0] VEC_TBASE = 12'h00a;
  localparam logic [11:0] VEC_EXT1 = 12'h00c;
  localparam logic [11:0] SHORT_CALL_N0 = 12'h086;
  localparam logic [11:0] SHORT_CALL_BASE = 12'h006;
  localparam logic [7:0] RAM_LAST = 8'hf3;
  localparam logic [7:0] DISP_LO = 8'h20;
  localparam logic [7:0] DISP_HI = 8'h3f;
  localparam logic [7:0] ZP_HI = 8'h0f;
  localparam logic [7:0] STACK_BASE = 8'hc0;
  localparam logic [3:0] STACK_LEVELS = 4'hd;
  // ram operation kinds
  typedef enum logic [3:0] {
    MMA_OP_NONE = 4'h0, MMA_OP_LD = 4'h1, MMA_OP_ST = 4'h2, MMA_OP_STD = 4'h3,
    MMA_OP_ADD = 4'h4, MMA_OP_CMP = 4'h5, MMA_OP_CLRB = 4'h6, MMA_OP_LOAD_POINTER_PAIR_FROM_RAM = 4'h7,
    MMA_OP_SWAP_POINTER_PAIR_WITH_RAM = 4'h8
  } mma_op_e;
  // flow kinds
  typedef enum logic [2:0] {
    MMA_FL_NEXT = 3'h0, MMA_FL_SHORT_CALL = 3'h1, MMA_FL_LONG_CALL = 3'h2,
    MMA_FL_RET = 3'h3, MMA_FL_IRQ = 3'h4, MMA_FL_JUMP = 3'h5
  } mma_flow_e;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    MMA_ST_IDLE = 4'b0001, MMA_ST_PUSH = 4'b0010, MMA_ST_POP = 4'b0100, MMA_ST_RMW = 4'b1000
  } mma_state_e;
endpackage : mma_pkg

// ==== core/mma_edge_wake.sv ====
// one wake-up pin: edge detector with build-time edge choice
// assumes pin is synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module mma_edge_wake #(
  parameter bit ENABLE = 1'b1,
  parameter bit POS_EDGE = 1'b0
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic pin, // port pin level
  output logic wake // one-cycle edge pulse
);
  logic prev_q;
  // remember last level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= pin;
    end
  end
  // configured edge only
  assign wake = ENABLE && (POS_EDGE ? (pin && !prev_q) : (!pin && prev_q));
endmodule : mma_edge_wake
`default_nettype wire

// ==== core/mma_stack.sv ====
// stack addressing: maps level and nibble to ram address
// assumes the caller sequences the three nibble writes
`timescale 1ns/10ps
`default_nettype none
module mma_stack (
  input wire logic [3:0] level, // stack level
  input wire logic [1:0] nib, // nibble within entry
  output logic [7:0] addr // ram address
);
  import mma_pkg::*;
  // four nibbles per level from the base
  assign addr = STACK_BASE + {2'b00, level, nib};
endmodule : mma_stack
`default_nettype wire

// ==== core/mma_addr_core.sv ====
// program counter, table pointer, stack and data ram address generation
// assumes the decoder presents one operation per pulse of op_valid
`timescale 1ns/10ps
`default_nettype none
module mma_addr_core #(
  parameter bit SOUND_EN = 1'b1,
  parameter logic [3:0] WAKE_EN = 4'hf,
  parameter logic [3:0] WAKE_POS = 4'h0
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic op_valid, // operation strobe
  input wire mma_pkg::mma_flow_e flow, // flow kind
  input wire mma_pkg::mma_op_e ram_op, // ram operation
  input wire logic direct_mode, // 1 direct, 0 indirect
  input wire logic [11:0] target, // jump or long call target
  input wire logic [3:0] short_call_n, // short call index
  input wire logic [2:0] irq_src, // 0..5 interrupt source
  input wire logic [1:0] pc_step, // instruction length
  input wire logic [7:0] operand, // direct ram address
  input wire logic [3:0] imm, // immediate nibble
  input wire logic [1:0] bit_sel, // bit for clear bit
  input wire logic [3:0] acc_in, // accumulator value
  input wire logic [1:0] tbl_ld, // 1 low,2 mid,3 high pointer load
  input wire logic [1:0] tbl_rd, // 1 low read,2 high read
  input wire logic sp_wr, // write stack pointer
  input wire logic [7:0] rom_data, // rom byte at rom_addr
  input wire logic [3:0] io_port_eight, // port eight pins
  input wire logic [3:0] input_port_zero, // port zero pins
  input wire logic melody, // melody waveform
  input wire logic io_p4_0_out, // port four bit 0 data
  output logic [11:0] pc_q, // program counter
  output logic [11:0] rom_addr, // rom address
  output logic [11:0] table_pointer_q, // table pointer
  output logic [3:0] stack_level_pointer_q, // stack pointer
  output logic [3:0] acc_out_q, // data to accumulator
  output logic acc_we_q, // accumulator load pulse
  output logic cmp_eq_q, // compare equal
  output logic refused_q, // operation refused
  output logic [3:0] ram_pair_q, // ram_pointer_pair high
  output logic [3:0] ram_pair_l_q, // ram_pointer_pair low
  output logic busy, // sequencer busy
  output logic timer_a_input, // timer a input
  output logic timer_b_input, // timer b input
  output logic wake_idle, // idle release pulse
  output logic io_p4_0_pin // port four bit 0 output
);
  import mma_pkg::*;
  logic [3:0] ram_q [0:243];
  mma_state_e st_q;
  logic [1:0] nib_q;
  logic [11:0] ret_q;
  logic [11:0] nxt_q;
  logic [11:0] pop_q;
  logic [7:0] ra;
  logic [7:0] stk_addr;
  logic [7:0] rmw_addr_q;
  mma_op_e rmw_op_q;
  logic [3:0] rmw_imm_q;
  logic [1:0] rmw_bit_q;
  logic [7:0] wake_v;
  logic [11:0] seq_pc;
  logic [11:0] vec;
  logic ra_ok;
  logic disp_hit;
  logic zp_op;
  logic [3:0] rd_nib;
  // stack slot address
  mma_stack u_stack (
    .level(stack_level_pointer_q),
    .nib(nib_q),
    .addr(stk_addr)
  );
  // wake-up detectors for port zero and port eight
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_wake
      mma_edge_wake #(.ENABLE(WAKE_EN[g]), .POS_EDGE(WAKE_POS[g])) u_w0 (
        .ref_clk(ref_clk), .rst_n(rst_n), .pin(input_port_zero[g]), .wake(wake_v[g])
      );
      mma_edge_wake #(.ENABLE(WAKE_EN[g]), .POS_EDGE(1'b0)) u_w8 (
        .ref_clk(ref_clk), .rst_n(rst_n), .pin(io_port_eight[g]), .wake(wake_v[g+4])
      );
    end
  endgenerate
  assign wake_idle = |wake_v;
  // pin routing
  assign timer_b_input = io_port_eight[1];
  assign timer_a_input = io_port_eight[3];
  assign io_p4_0_pin = SOUND_EN ? ~melody : io_p4_0_out;
  // address mode selection
  always_comb begin
    ra = direct_mode ? operand : {ram_pair_q, ram_pair_l_q};
    zp_op = (ram_op == MMA_OP_STD) || (ram_op == MMA_OP_ADD) ||
      (ram_op == MMA_OP_CMP) || (ram_op == MMA_OP_CLRB);
    if (zp_op) begin
      ra = operand;
    end
    disp_hit = (ra >= DISP_LO) && (ra <= DISP_HI) &&
      ((ram_op == MMA_OP_LOAD_POINTER_PAIR_FROM_RAM) || (ram_op == MMA_OP_SWAP_POINTER_PAIR_WITH_RAM));
    ra_ok = (ra <= RAM_LAST) && !disp_hit && !(zp_op && (operand > ZP_HI));
    rd_nib = (ra <= RAM_LAST) ? ram_q[ra] : 4'h0;
  end
  // interrupt vector table
  always_comb begin
    unique case (irq_src)
      3'd0: vec = VEC_EXT0;
      3'd1: vec = VEC_FAST;
      3'd2: vec = VEC_TMRA;
      3'd3: vec = VEC_TMRB;
      3'd4: vec = VEC_TBASE;
      default: vec = VEC_EXT1;
    endcase
  end
  // target of the current flow op
  always_comb begin
    seq_pc = pc_q + {10'h000, pc_step};
    unique case (flow)
      MMA_FL_SHORT_CALL: seq_pc = (short_call_n == 4'h0) ? SHORT_CALL_N0 :
        (SHORT_CALL_BASE + {5'h00, short_call_n, 3'b000});
      MMA_FL_LONG_CALL: seq_pc = {1'b0, target[10:0]};
      MMA_FL_IRQ: seq_pc = vec;
      MMA_FL_JUMP: seq_pc = target;
      default: seq_pc = pc_q + {10'h000, pc_step};
    endcase
  end
  assign rom_addr = (tbl_rd != 2'd0) ? table_pointer_q : pc_q;
  assign busy = (st_q != MMA_ST_IDLE);
  // sequencer: push, pop and read-modify-write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q <= MMA_ST_IDLE;
      nib_q <= 2'd0;
      pc_q <= RESET_VEC;
      ret_q <= 12'h000;
      nxt_q <= 12'h000;
      pop_q <= 12'h000;
      rmw_addr_q <= 8'h00;
      rmw_op_q <= MMA_OP_NONE;
      rmw_imm_q <= 4'h0;
      rmw_bit_q <= 2'd0;
    end else begin
      unique case (st_q)
        MMA_ST_IDLE: begin
          if (op_valid) begin
            nib_q <= 2'd0;
            if (flow == MMA_FL_SHORT_CALL || flow == MMA_FL_LONG_CALL || flow == MMA_FL_IRQ) begin
              // return address: next op for calls, current pc for interrupts
              ret_q <= (flow == MMA_FL_IRQ) ? pc_q : pc_q + {10'h000, pc_step};
              nxt_q <= seq_pc;
              st_q <= MMA_ST_PUSH;
            end else if (flow == MMA_FL_RET) begin
              st_q <= MMA_ST_POP;
            end else begin
              pc_q <= seq_pc;
              if (zp_op && ra_ok && ram_op != MMA_OP_STD) begin
                rmw_addr_q <= ra;
                rmw_op_q <= ram_op;
                rmw_imm_q <= imm;
                rmw_bit_q <= bit_sel;
                st_q <= MMA_ST_RMW;
              end
            end
          end
        end
        MMA_ST_PUSH: begin
          nib_q <= nib_q + 2'd1;
          if (nib_q == 2'd2) begin
            pc_q <= nxt_q;
            st_q <= MMA_ST_IDLE;
          end
        end
        MMA_ST_POP: begin
          nib_q <= nib_q + 2'd1;
          pop_q <= {ram_q[stk_addr], pop_q[11:4]};
          if (nib_q == 2'd2) begin
            pc_q <= {ram_q[stk_addr], pop_q[11:4]};
            st_q <= MMA_ST_IDLE;
          end
        end
        MMA_ST_RMW: begin
          st_q <= MMA_ST_IDLE;
        end
        default: st_q <= MMA_ST_IDLE;
      endcase
    end
  end
  // stack pointer: software load, no reset value
  always_ff @(posedge ref_clk) begin
    if (st_q == MMA_ST_IDLE && op_valid && sp_wr) begin
      stack_level_pointer_q <= acc_in;
    end else if (st_q == MMA_ST_IDLE && op_valid && flow == MMA_FL_RET) begin
      stack_level_pointer_q <= stack_level_pointer_q + 4'd1;
    end else if (st_q == MMA_ST_PUSH && nib_q == 2'd2) begin
      stack_level_pointer_q <= stack_level_pointer_q - 4'd1;
    end
  end
  // ram writes: stack, stores and zero-page results
  always_ff @(posedge ref_clk) begin
    if (st_q == MMA_ST_PUSH) begin
      ram_q[stk_addr] <= ret_q[4*nib_q +: 4];
    end else if (st_q == MMA_ST_RMW) begin
      unique case (rmw_op_q)
        MMA_OP_ADD: ram_q[rmw_addr_q] <= ram_q[rmw_addr_q] + rmw_imm_q;
        MMA_OP_CLRB: ram_q[rmw_addr_q][rmw_bit_q] <= 1'b0;
        default: ram_q[rmw_addr_q] <= ram_q[rmw_addr_q];
      endcase
    end else if (st_q == MMA_ST_IDLE && op_valid && ra_ok) begin
      if (ram_op == MMA_OP_ST) begin
        ram_q[ra] <= acc_in;
      end else if (ram_op == MMA_OP_STD) begin
        ram_q[ra] <= imm;
      end else if (ram_op == MMA_OP_SWAP_POINTER_PAIR_WITH_RAM) begin
        ram_q[ra] <= ram_pair_l_q;
        ram_q[ra + 8'h01] <= ram_pair_q;
      end
    end
  end
  // ram pointer pair load and swap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ram_pair_q <= 4'h0;
      ram_pair_l_q <= 4'h0;
    end else if (st_q == MMA_ST_IDLE && op_valid && ra_ok &&
        (ram_op == MMA_OP_LOAD_POINTER_PAIR_FROM_RAM || ram_op == MMA_OP_SWAP_POINTER_PAIR_WITH_RAM)) begin
      ram_pair_l_q <= rd_nib;
      ram_pair_q <= ram_q[ra + 8'h01];
    end
  end
  // table pointer loads and high read increment
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      table_pointer_q <= 12'h000;
    end else if (st_q == MMA_ST_IDLE && op_valid) begin
      unique case (tbl_ld)
        2'd1: table_pointer_q[3:0] <= acc_in;
        2'd2: table_pointer_q[5:4] <= acc_in[1:0];
        2'd3: table_pointer_q[8:6] <= acc_in[2:0];
        default: begin
          if (tbl_rd == 2'd2) begin
            table_pointer_q <= table_pointer_q + 12'h001;
          end
        end
      endcase
    end
  end
  // answers to the accumulator and status
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_out_q <= 4'h0;
      acc_we_q <= 1'b0;
      cmp_eq_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      acc_we_q <= 1'b0;
      refused_q <= 1'b0;
      if (st_q == MMA_ST_IDLE && op_valid) begin
        refused_q <= (ram_op != MMA_OP_NONE) && !ra_ok;
        if (tbl_rd == 2'd1) begin
          acc_out_q <= rom_data[3:0];
          acc_we_q <= 1'b1;
        end else if (tbl_rd == 2'd2) begin
          acc_out_q <= rom_data[7:4];
          acc_we_q <= 1'b1;
        end else if (ram_op == MMA_OP_LD && ra_ok) begin
          acc_out_q <= rd_nib;
          acc_we_q <= 1'b1;
        end else if (ram_op == MMA_OP_CMP && ra_ok) begin
          cmp_eq_q <= (rd_nib == imm);
        end
      end
    end
  end
endmodule : mma_addr_core
`default_nettype wire

// ==== verif/mma_rom_model.sv ====
// program rom model with a fixed byte pattern
// assumes the core reads it combinationally
`timescale 1ns/10ps
`default_nettype none
module mma_rom_model (
  input wire logic [11:0] addr, // rom address
  output logic [7:0] data // rom byte
);
  // neighbours differ, so a wrong address shows
  assign data = addr[7:0] ^ {addr[11:8], addr[11:8]} ^ 8'h5a;
endmodule : mma_rom_model
`default_nettype wire

// ==== verif/mma_addr_checker.sv ====
// port checks for the address core
// assumes requests are held until taken while busy is low
`timescale 1ns/10ps
`default_nettype none
module mma_addr_checker
  import mma_pkg::*;
#(
  parameter bit SOUND_EN = 1'b1
) (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic op_valid, // strobe
  input wire mma_pkg::mma_flow_e flow, // flow
  input wire mma_pkg::mma_op_e ram_op, // ram op
  input wire logic direct_mode, // mode
  input wire logic [11:0] target, // target
  input wire logic [3:0] short_call_n, // index
  input wire logic [2:0] irq_src, // source
  input wire logic [7:0] operand, // operand
  input wire logic [1:0] tbl_rd, // table read
  input wire logic [7:0] rom_data, // rom byte
  input wire logic [3:0] io_port_eight, // port
  input wire logic melody, // melody
  input wire logic [11:0] pc_q, // pc
  input wire logic [11:0] table_pointer_q, // pointer
  input wire logic [3:0] stack_level_pointer_q, // sp
  input wire logic [3:0] acc_out_q, // acc data
  input wire logic acc_we_q, // acc load
  input wire logic refused_q, // refused
  input wire logic busy, // busy
  input wire logic timer_a_input, // timer a
  input wire logic timer_b_input, // timer b
  input wire logic io_p4_0_pin // sound pin
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic [3:0] rom_lo, rom_hi, sp_q;
  logic [11:0] exp_q;
  // request taken, rom nibbles
  assign take = op_valid && !busy;
  assign rom_lo = rom_data[3:0];
  assign rom_hi = rom_data[7:4];
  // expected call target and level at each take
  always_ff @(posedge ref_clk) begin
    if (take) begin
      exp_q <= (flow == MMA_FL_LONG_CALL) ? {1'b0, target[10:0]} :
               (flow == MMA_FL_IRQ) ? {8'h00, irq_src + 3'h1, 1'b0} :
               (short_call_n == 4'h0) ? 12'h086 : {5'h00, short_call_n, 3'h6};
      sp_q <= stack_level_pointer_q;
    end
  end
  a_reset_fetch: assert property ($rose(rst_n) |-> pc_q == 12'h000 && !busy)
    else $error("fetch does not start at zero");
  a_timer_route: assert property (timer_a_input == io_port_eight[3] &&
    timer_b_input == io_port_eight[1]) else $error("timer input routing wrong");
  a_sound_out: assert property (!SOUND_EN || io_p4_0_pin == ~melody)
    else $error("sound pin not inverted melody");
  a_tbl_low: assert property (take && tbl_rd == 2'h1 |=> acc_we_q &&
    acc_out_q == $past(rom_lo) && $stable(table_pointer_q)) else $error("low read wrong");
  a_tbl_high: assert property (take && tbl_rd == 2'h2 |=> acc_we_q &&
    acc_out_q == $past(rom_hi) && table_pointer_q == $past(table_pointer_q) + 12'h001)
    else $error("high read wrong");
  a_long_call_sched: assert property (take && flow == MMA_FL_LONG_CALL |=>
    busy[*3] ##1 (!busy && pc_q == exp_q)) else $error("long call wrong");
  a_short_call_target: assert property (take && flow == MMA_FL_SHORT_CALL |=>
    ##[2:4] (!busy && pc_q == exp_q)) else $error("short call target wrong");
  a_irq_vector: assert property (take && flow == MMA_FL_IRQ |=>
    ##[2:4] (!busy && pc_q == exp_q)) else $error("vector wrong");
  a_call_level: assert property (take && flow == MMA_FL_SHORT_CALL |=>
    ##[2:4] (!busy && stack_level_pointer_q == sp_q - 4'h1)) else $error("level wrong");
  a_zp_refuse: assert property (take && operand > 8'h0f && ram_op inside
    {MMA_OP_STD, MMA_OP_ADD, MMA_OP_CMP, MMA_OP_CLRB} |=> refused_q)
    else $error("zero page op outside zero page");
  a_disp_refuse: assert property (take && direct_mode && ram_op inside
    {MMA_OP_LOAD_POINTER_PAIR_FROM_RAM, MMA_OP_SWAP_POINTER_PAIR_WITH_RAM} && operand inside {[8'h20:8'h3f]} |=> refused_q)
    else $error("display ram pair op not refused");
endmodule : mma_addr_checker
bind mma_addr_core mma_addr_checker #(.SOUND_EN(SOUND_EN)) u_checker (.*);
`default_nettype wire

// ==== verif/mma_addr_core_tb.sv ====
// self-checking bench for the address core
// assumes a combinational rom partner and the package constants
`timescale 1ns/10ps
`default_nettype none
module mma_addr_core_tb;
  import mma_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  logic direct_mode = 1'b1;
  logic sp_wr = 1'b0;
  logic melody = 1'b0;
  logic io_p4_0_out = 1'b0;
  mma_flow_e flow = MMA_FL_NEXT;
  mma_op_e ram_op = MMA_OP_NONE;
  logic [11:0] target = 12'h000;
  logic [3:0] short_call_n = 4'h0, imm = 4'h0, acc_in = 4'h0;
  logic [3:0] io_port_eight = 4'hf, input_port_zero = 4'hf;
  logic [2:0] irq_src = 3'h0;
  logic [1:0] pc_step = 2'h1, bit_sel = 2'h0, tbl_ld = 2'h0, tbl_rd = 2'h0;
  logic [7:0] operand = 8'h00;
  logic [7:0] rom_data;
  logic [11:0] pc_q, rom_addr, table_pointer_q;
  logic [3:0] stack_level_pointer_q, acc_out_q, ram_pair_q, ram_pair_l_q, acc_seen;
  logic acc_we_q, cmp_eq_q, refused_q, busy, timer_a_input, timer_b_input;
  logic wake_idle, io_p4_0_pin, we_seen, ref_seen;
  int error_cnt = 0;
  int total_checks = 0;
  mma_addr_core dut (.*);
  mma_rom_model u_rom (.addr(rom_addr), .data(rom_data));
  // 50 mhz clock
  always #10 ref_clk = ~ref_clk;
  function automatic logic [3:0] rom_nib(input logic [11:0] a, input bit hi);
    logic [7:0] b;
    b = a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
    return hi ? b[7:4] : b[3:0];
  endfunction : rom_nib
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // one operation: strobe, capture one-cycle answers, wait for idle
  task automatic issue(input mma_flow_e f, input mma_op_e r, input logic [7:0] a,
      input logic [3:0] i = 4'h0, input logic [11:0] t = 12'h000,
      input logic [1:0] ld = 2'h0, input logic [1:0] rd = 2'h0, input logic sp = 1'b0,
      input logic dm = 1'b1);
    @(posedge ref_clk);
    {flow, ram_op, operand, imm, acc_in, bit_sel} <= {f, r, a, i, i, i[1:0]};
    {target, short_call_n, irq_src, tbl_ld, tbl_rd} <= {t, i, i[2:0], ld, rd};
    {sp_wr, direct_mode, op_valid} <= {sp, dm, 1'b1};
    @(posedge ref_clk);
    {op_valid, tbl_ld, tbl_rd, sp_wr} <= 6'h00;
    #1;
    {acc_seen, we_seen, ref_seen} = {acc_out_q, acc_we_q, refused_q};
    repeat (8) if (busy !== 1'b0) @(posedge ref_clk) #1;
    check("idle", 12'h000, busy);
  endtask : issue
  task automatic t_table;
    issue(MMA_FL_NEXT, MMA_OP_NONE, 8'h00, 4'hf, 12'h000, 2'h1);
    issue(MMA_FL_NEXT, MMA_OP_NONE, 8'h00, 4'h1, 12'h000, 2'h2);
    issue(MMA_FL_NEXT, MMA_OP_NONE, 8'h00, 4'h5, 12'h000, 2'h3);
    check("pointer", 12'h15f, table_pointer_q);
    issue(MMA_FL_NEXT, MMA_OP_NONE, 8'h00, 4'h0, 12'h000, 2'h0, 2'h1);
    check("low nibble", rom_nib(12'h15f, 0), acc_seen);
    check("pointer kept", 12'h15f, table_pointer_q);
    for (int k = 0; k < 2; k++) begin
      issue(MMA_FL_NEXT, MMA_OP_NONE, 8'h00, 4'h0, 12'h000, 2'h0, 2'h2);
      check("high nibble", rom_nib(12'h15f + 12'(k), 1), acc_seen);
      check("pointer step", 12'h160 + 12'(k), table_pointer_q);
    end
  endtask : t_table
  task automatic call_ret(input mma_flow_e f, input logic [3:0] i, input logic [11:0] t,
      input logic [11:0] exp, input logic [11:0] back);
    issue(MMA_FL_JUMP, MMA_OP_NONE, 8'h00, 4'h0, 12'h500);
    issue(f, MMA_OP_NONE, 8'h00, i, t);
    check("call target", exp, pc_q);
    check("level in call", 12'h00b, stack_level_pointer_q);
    issue(MMA_FL_RET, MMA_OP_NONE, 8'h00);
    check("return pc", back, pc_q);
    check("level back", 12'h00c, stack_level_pointer_q);
  endtask : call_ret
  task automatic t_calls;
    issue(MMA_FL_NEXT, MMA_OP_NONE, 8'h00, 4'hc, 12'h000, 2'h0, 2'h0, 1'b1);
    check("start level", 12'h00c, stack_level_pointer_q);
    call_ret(MMA_FL_LONG_CALL, 4'h0, 12'habc, 12'h2bc, 12'h501);
    for (int n = 0; n < 16; n++)
      call_ret(MMA_FL_SHORT_CALL, 4'(n), 12'h000, n == 0 ? 12'h086 : 12'(8 * n + 6), 12'h501);
    for (int s = 0; s < 6; s++)
      call_ret(MMA_FL_IRQ, 4'(s), 12'h000, 12'(2 * s + 2), 12'h500);
  endtask : t_calls
  task automatic t_ram;
    issue(MMA_FL_NEXT, MMA_OP_ST, 8'h45, 4'h9);
    issue(MMA_FL_NEXT, MMA_OP_ST, 8'h50, 4'h5);
    issue(MMA_FL_NEXT, MMA_OP_ST, 8'h51, 4'h4);
    issue(MMA_FL_NEXT, MMA_OP_LOAD_POINTER_PAIR_FROM_RAM, 8'h50);
    check("pair", 12'h045, {ram_pair_q, ram_pair_l_q});
    issue(MMA_FL_NEXT, MMA_OP_LD, 8'h00, 4'h0, 12'h000, 2'h0, 2'h0, 1'b0, 1'b0);
    check("indirect load", 12'h009, acc_seen);
    issue(MMA_FL_NEXT, MMA_OP_LD, 8'h45);
    check("direct load", 12'h009, acc_seen);
    issue(MMA_FL_NEXT, MMA_OP_LOAD_POINTER_PAIR_FROM_RAM, 8'h25);
    check("pair load refused", 12'h001, ref_seen);
    issue(MMA_FL_NEXT, MMA_OP_SWAP_POINTER_PAIR_WITH_RAM, 8'h3f);
    check("swap refused", 12'h001, ref_seen);
    issue(MMA_FL_NEXT, MMA_OP_LD, 8'hf4);
    check("beyond ram", 12'h001, ref_seen);
    issue(MMA_FL_NEXT, MMA_OP_LD, 8'hf3);
    check("last ram", 12'h000, ref_seen);
    issue(MMA_FL_NEXT, MMA_OP_STD, 8'h03, 4'h7);
    issue(MMA_FL_NEXT, MMA_OP_ADD, 8'h03, 4'h5);
    issue(MMA_FL_NEXT, MMA_OP_LD, 8'h03);
    check("zero page add", 12'h00c, acc_seen);
    issue(MMA_FL_NEXT, MMA_OP_CMP, 8'h03, 4'hc);
    check("compare", 12'h001, cmp_eq_q);
    issue(MMA_FL_NEXT, MMA_OP_CLRB, 8'h03, 4'h2);
    issue(MMA_FL_NEXT, MMA_OP_LD, 8'h03);
    check("clear bit", 12'h008, acc_seen);
    issue(MMA_FL_NEXT, MMA_OP_STD, 8'h10, 4'h1);
    check("zero page only", 12'h001, ref_seen);
  endtask : t_ram
  task automatic t_pins;
    @(posedge ref_clk);
    {io_port_eight, melody} <= {4'b1000, 1'b1};
    @(posedge ref_clk);
    input_port_zero <= 4'hb;
    #1;
    check("timer pins", 12'h002, {timer_a_input, timer_b_input});
    check("sound pin", 12'h000, io_p4_0_pin);
    check("wake pulse", 12'h001, wake_idle);
    @(posedge ref_clk);
    #1;
    check("wake ends", 12'h000, wake_idle);
  endtask : t_pins
  // hang guard
  initial begin
    repeat (8000) @(posedge ref_clk);
    error_cnt++;
    end_of_test();
  end
  // reset, then the scenarios
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    check("reset pc", 12'h000, pc_q);
    check("reset pointer", 12'h000, table_pointer_q);
    t_table();
    t_calls();
    t_ram();
    t_pins();
    end_of_test();
  end
endmodule : mma_addr_core_tb
`default_nettype wire
